// ===== rtl/tao_alarm_top.sv
// Thermal alarm outputs: critical pin, alert pin, status and config registers.
// Assumes a byte register port fed by the serial bus front end, on clk_sys.
//
// Notes on behaviour
// - Critical pin drives only when its enable bit is one; else floats.
// - Temperature at or above a critical limit sets that channel's flag.
// - Read clears critical flag; re-set only after falling five degrees.
// - Critical pin stays low until temperature falls five degrees below.
// - Remote sensor failure sets its flag and forces critical pin low.
// - Failure flag and low pin latch until power-on or software reset.
// - Failure flag raises an alert only when its enable is one.
// - Alert pin is an open-drain interrupt line.
// - Limit events set flags; enabled flags pull the alert pin low.
// - Generic flags stay set until the condition ends and status is read.
// - Alert stays low while out of limits and until status is read.
// - A cleared enable masks only the alert; the flag still sets.
// - Registers are 8 bits; reserved reads zero and ignores writes.
`timescale 1ns/1ns
module tao_alarm_top #(
   parameter int TW = 8,
   parameter logic [7:0] PART_ID = 8'h5A,       // Arbitrary value.
   parameter logic [7:0] MAKER_ID = 8'hA5,      // Arbitrary value.
   parameter logic [3:0] REVISION = 4'h3        // Arbitrary value.
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Register port.
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData_r,
   output logic regRdValid_r,
   // Temperatures and critical limits.
   input wire logic signed [TW-1:0] localTemp,
   input wire logic signed [TW-1:0] remoteTemp,
   input wire logic signed [TW-1:0] localCritLimit,
   input wire logic signed [TW-1:0] remoteCritLimit,
   // Event conditions from the monitor.
   input wire logic remoteFailDet,
   input wire logic [15:0] limitCond,
   // Configuration seen by the rest of the device.
   output logic [7:0] mainCfg_r,
   output logic [7:0] irqCfg_r,
   output logic [7:0] outCfg_r,
   output logic thermFanEn_r,
   output logic swRstPulse_r,
   // Critical alert pin, open drain.
   input wire logic critical_alert_pin_i,
   output logic critical_alert_pin_o,
   output logic critical_alert_pin_oe_r,
   // Alert pin, open drain.
   input wire logic alert_pin_i,
   output logic alert_pin_o,
   output logic alert_pin_oe_r
);
   tao_sticky_if #(.W(tao_pkg::STAT_W)) stickyIf ();

   tao_pkg::tao_status_type statusVec;
   tao_pkg::tao_status_type irqEnVec;
   tao_pkg::tao_status_type rdClrVec;
   logic remote_sensor_fail_flag;
   logic local_over_critical_flag;
   logic remoteOverCritFlag;
   logic localPinHold;
   logic remotePinHold;
   logic critical_pin_enable;
   logic remote_fail_irq_enable;
   logic therm_limit_irq_enable;
   logic speed_irq_enable;
   logic passive_cooling_irq_enable;
   logic remote_temp_irq_enable;
   logic local_temp_irq_enable;
   logic globalIrqEn;
   logic rdStat1;
   logic rdStat2;
   logic wrMain;
   logic wrIrq;
   logic wrOut;
   logic wrRev;
   logic swRstReq;
   logic critPinNxt;
   logic alertNxt;
   logic [7:0] rdMux;
   logic rtf_r;

   if (TW != tao_pkg::DATA_W) begin : g_chk
      $error("tao_alarm_top serves only 8-bit temperature bytes.");
   end

   // Address match, shared by the read and write decode.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction : hit

   // Register read selection; unmapped and reserved bits read zero.
   function automatic logic [7:0] readSel(
      input logic [7:0] a,
      input logic [7:0] mc,
      input logic [7:0] ic,
      input logic [7:0] oc,
      input logic tf,
      input tao_pkg::tao_status_type st
   );
      readSel = 8'h00;
      case (a)
         tao_pkg::ADDR_MAIN_CFG: readSel = mc;
         // The software reset bit is a trigger and reads back zero.
         tao_pkg::ADDR_IRQ_CFG: readSel = ic;
         tao_pkg::ADDR_STAT1: readSel = st[7:0];
         tao_pkg::ADDR_STAT2: readSel = st[15:8];
         tao_pkg::ADDR_OUT_CFG: readSel = oc;
         tao_pkg::ADDR_PART_ID: readSel = PART_ID;
         tao_pkg::ADDR_MAKER_ID: readSel = MAKER_ID;
         tao_pkg::ADDR_REV_CFG: readSel = {tf, {(8 - 1 - tao_pkg::REV_W){1'b0}}, REVISION};
         default: readSel = 8'h00;
      endcase
   endfunction : readSel

   // Enable bits named from what they gate.
   assign critical_pin_enable = outCfg_r[tao_pkg::B_CRIT_PIN_EN];
   assign remote_fail_irq_enable = irqCfg_r[tao_pkg::B_REMOTE_FAIL_IRQ_EN];
   assign therm_limit_irq_enable = mainCfg_r[tao_pkg::B_THERM_IRQ_EN];
   assign speed_irq_enable = mainCfg_r[tao_pkg::B_SPEED_IRQ_EN];
   assign globalIrqEn = mainCfg_r[tao_pkg::B_GLOBAL_IRQ_EN];
   assign passive_cooling_irq_enable = irqCfg_r[tao_pkg::B_PASSIVE_IRQ_EN];
   assign remote_temp_irq_enable = irqCfg_r[tao_pkg::B_REMOTE_TEMP_IRQ_EN];
   assign local_temp_irq_enable = irqCfg_r[tao_pkg::B_LOCAL_TEMP_IRQ_EN];

   // Strobe decode from the register port.
   assign rdStat1 = regRdEn && hit(regAddr, tao_pkg::ADDR_STAT1);
   assign rdStat2 = regRdEn && hit(regAddr, tao_pkg::ADDR_STAT2);
   assign wrMain = regWrEn && hit(regAddr, tao_pkg::ADDR_MAIN_CFG);
   assign wrIrq = regWrEn && hit(regAddr, tao_pkg::ADDR_IRQ_CFG);
   assign wrOut = regWrEn && hit(regAddr, tao_pkg::ADDR_OUT_CFG);
   assign wrRev = regWrEn && hit(regAddr, tao_pkg::ADDR_REV_CFG);
   assign swRstReq = wrIrq && regWrData[tao_pkg::B_SOFT_RESET];
   assign rdClrVec = {{8{rdStat2}}, {8{rdStat1}}};

   // Generic sticky flags; special bits are masked off here and built below.
   // flags on events
   assign stickyIf.cond = limitCond & tao_pkg::GENERIC_MASK;
   assign stickyIf.rdClr = rdClrVec;

   tao_sticky_bank #(
      .W(tao_pkg::STAT_W)
   ) u_sticky (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .sif(stickyIf)
   );

   // Both critical channels share one module.
   // per-channel critical flag
   tao_crit_chan #(
      .TW(TW)
   ) u_local_crit (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .swRst(swRstPulse_r),
      .temp(localTemp),
      .critLimit(localCritLimit),
      .rdClr(rdStat2),
      .overFlag(local_over_critical_flag),
      .pinHold(localPinHold)
   );

   tao_crit_chan #(
      .TW(TW)
   ) u_remote_crit (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .swRst(swRstPulse_r),
      .temp(remoteTemp),
      .critLimit(remoteCritLimit),
      .rdClr(rdStat2),
      .overFlag(remoteOverCritFlag),
      .pinHold(remotePinHold)
   );

   // Failure latch: reading status never clears it, a live failure beats a software reset.
   // failure latch
   always_ff @(posedge clk_sys) begin
      if (!nrst) rtf_r <= 1'b0;
      else rtf_r <= remoteFailDet || (rtf_r && !swRstPulse_r);
   end
   assign remote_sensor_fail_flag = rtf_r;

   // Merge the special flags into the status vector.
   always_comb begin
      statusVec = stickyIf.flags;
      statusVec[tao_pkg::ST_REMOTE_FAIL] = remote_sensor_fail_flag;
      statusVec[tao_pkg::ST_LOCAL_CRIT] = local_over_critical_flag;
      statusVec[tao_pkg::ST_REMOTE_CRIT] = remoteOverCritFlag;
   end

   // Interrupt enable per status bit; reserved bits never interrupt.
   // failure alert gate
   always_comb begin
      irqEnVec = '0;
      irqEnVec[tao_pkg::ST_SPEED_HIGH] = speed_irq_enable;
      irqEnVec[tao_pkg::ST_SPEED_LOW] = speed_irq_enable;
      irqEnVec[tao_pkg::ST_REMOTE_HIGH] = remote_temp_irq_enable;
      irqEnVec[tao_pkg::ST_REMOTE_LOW] = remote_temp_irq_enable;
      irqEnVec[tao_pkg::ST_REMOTE_THERM] = therm_limit_irq_enable;
      irqEnVec[tao_pkg::ST_REMOTE_FAIL] = remote_fail_irq_enable;
      irqEnVec[tao_pkg::ST_LOCAL_HIGH] = local_temp_irq_enable;
      irqEnVec[tao_pkg::ST_LOCAL_LOW] = local_temp_irq_enable;
      irqEnVec[tao_pkg::ST_REMOTE_CRIT] = therm_limit_irq_enable;
      irqEnVec[tao_pkg::ST_LOCAL_CRIT] = therm_limit_irq_enable;
      irqEnVec[tao_pkg::ST_LOCAL_PASSIVE] = passive_cooling_irq_enable;
      irqEnVec[tao_pkg::ST_LOCAL_THERM] = therm_limit_irq_enable;
      irqEnVec[tao_pkg::ST_THERM_INPUT] = therm_limit_irq_enable;
   end

   // Alert follows the flags, so it stays low until they clear after a read.
   // mask gates alert only
   assign alertNxt = globalIrqEn && |(statusVec & irqEnVec);

   // Critical pin: enabled, and a held critical level or a latched failure.
   // pin enable gate
   assign critPinNxt = critical_pin_enable &&
      (localPinHold || remotePinHold || remote_sensor_fail_flag);

   // Both pins only ever pull low; the level leaves them through the enables.
   // open-drain alert line
   assign alert_pin_o = 1'b0;
   assign critical_alert_pin_o = 1'b0;

   // Pin enables.
   // alert tracks flags
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         alert_pin_oe_r <= 1'b0;
         critical_alert_pin_oe_r <= 1'b0;
      end else begin
         alert_pin_oe_r <= alertNxt;
         critical_alert_pin_oe_r <= critPinNxt;
      end
   end

   // Configuration registers; a software reset restores all of them.
   // fixed low nibble
   always_ff @(posedge clk_sys) begin
      if (!nrst || swRstPulse_r) begin
         mainCfg_r <= tao_pkg::RST_MAIN_CFG;
         irqCfg_r <= tao_pkg::RST_IRQ_CFG;
         outCfg_r <= tao_pkg::RST_OUT_CFG;
         thermFanEn_r <= tao_pkg::RST_THERM_FAN_EN;
      end else begin
         if (wrMain) mainCfg_r <= regWrData;
         if (wrIrq) irqCfg_r <= regWrData & ~(8'h01 << tao_pkg::B_SOFT_RESET);
         if (wrOut) outCfg_r <= (regWrData & ~tao_pkg::OUT_CFG_FIXED_MASK) |
            (tao_pkg::RST_OUT_CFG & tao_pkg::OUT_CFG_FIXED_MASK);
         if (wrRev) thermFanEn_r <= regWrData[tao_pkg::B_THERM_FAN_EN];
      end
   end

   // Software reset trigger, one cycle after the write.
   always_ff @(posedge clk_sys) begin
      if (!nrst) swRstPulse_r <= 1'b0;
      else swRstPulse_r <= swRstReq;
   end

   // Read data returns the value before any read-clear takes effect.
   // reserved reads zero
   assign rdMux = readSel(regAddr, mainCfg_r, irqCfg_r, outCfg_r, thermFanEn_r, statusVec);

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         regRdData_r <= 8'h00;
         regRdValid_r <= 1'b0;
      end else begin
         regRdValid_r <= regRdEn;
         if (regRdEn) regRdData_r <= rdMux;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   property p_pin_off;
      !critical_pin_enable |=> !critical_alert_pin_oe_r;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("Critical pin driven while off.");

   sequence s_fail_seen;
      remoteFailDet && !swRstPulse_r ##1 critical_pin_enable && !swRstPulse_r;
   endsequence
   property p_fail_pin;
      s_fail_seen |=> critical_alert_pin_oe_r && remote_sensor_fail_flag;
   endproperty
   a_fail_pin: assert property (p_fail_pin) else $error("Failure did not pull pin.");

   property p_fail_latch;
      (remote_sensor_fail_flag && !swRstPulse_r) |=> remote_sensor_fail_flag;
   endproperty
   a_fail_latch: assert property (p_fail_latch) else $error("Failure flag dropped.");

   property p_masked_quiet;
      (!globalIrqEn || (statusVec & irqEnVec) == '0) |=> !alert_pin_oe_r;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) else $error("Alert with no source.");

   property p_alert_on;
      (globalIrqEn && remote_fail_irq_enable && remote_sensor_fail_flag) |=> alert_pin_oe_r;
   endproperty
   a_alert_on: assert property (p_alert_on) else $error("Enabled failure gave no alert.");

   property p_unmapped_zero;
      (regRdEn && !hit(regAddr, tao_pkg::ADDR_MAIN_CFG) && !hit(regAddr, tao_pkg::ADDR_IRQ_CFG)
         && !hit(regAddr, tao_pkg::ADDR_STAT1) && !hit(regAddr, tao_pkg::ADDR_STAT2)
         && !hit(regAddr, tao_pkg::ADDR_OUT_CFG) && !hit(regAddr, tao_pkg::ADDR_PART_ID)
         && !hit(regAddr, tao_pkg::ADDR_MAKER_ID) && !hit(regAddr, tao_pkg::ADDR_REV_CFG))
         |=> regRdValid_r && regRdData_r == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("Reserved read not zero.");
endmodule : tao_alarm_top

// ===== rtl/tao_pkg.sv
// Constants shared by the thermal alarm output logic.
// Assumes 8-bit registers and 1 degree C per temperature LSB.
package tao_pkg;
   localparam int DATA_W = 8;
   localparam int STAT_W = 16;
   // Register addresses.
   localparam logic [7:0] ADDR_MAIN_CFG = 8'h00;
   localparam logic [7:0] ADDR_IRQ_CFG = 8'h01;
   localparam logic [7:0] ADDR_STAT1 = 8'h02;
   localparam logic [7:0] ADDR_STAT2 = 8'h03;
   localparam logic [7:0] ADDR_OUT_CFG = 8'h04;
   localparam logic [7:0] ADDR_PART_ID = 8'h3D;
   localparam logic [7:0] ADDR_MAKER_ID = 8'h3E;
   localparam logic [7:0] ADDR_REV_CFG = 8'h3F;
   // Reset values.
   localparam logic [7:0] RST_MAIN_CFG = 8'hD4;
   localparam logic [7:0] RST_IRQ_CFG = 8'h3D;
   localparam logic [7:0] RST_OUT_CFG = 8'h08;
   localparam logic RST_THERM_FAN_EN = 1'b1;
   // Fields of main_config.
   localparam int B_THERM_IRQ_EN = 7;
   localparam int B_SPEED_IRQ_EN = 2;
   localparam int B_GLOBAL_IRQ_EN = 1;
   // Fields of irq_and_tach_config.
   localparam int B_SOFT_RESET = 7;
   localparam int B_PASSIVE_IRQ_EN = 6;
   localparam int B_REMOTE_TEMP_IRQ_EN = 5;
   localparam int B_LOCAL_TEMP_IRQ_EN = 4;
   localparam int B_REMOTE_FAIL_IRQ_EN = 3;
   // Fields of output_and_tach_speed_config (low nibble fixed) and of the revision register.
   localparam int B_CRIT_PIN_EN = 4;
   localparam logic [7:0] OUT_CFG_FIXED_MASK = 8'h0F;
   localparam int B_THERM_FAN_EN = 7;
   localparam int REV_W = 4;
   // Status vector: status register one in [7:0], two in [15:8].
   localparam int ST_SPEED_HIGH = 0;
   localparam int ST_SPEED_LOW = 1;
   localparam int ST_REMOTE_HIGH = 2;
   localparam int ST_REMOTE_LOW = 3;
   localparam int ST_REMOTE_THERM = 4;
   localparam int ST_REMOTE_FAIL = 5;
   localparam int ST_LOCAL_HIGH = 6;
   localparam int ST_LOCAL_LOW = 7;
   localparam int ST_REMOTE_CRIT = 11;
   localparam int ST_LOCAL_CRIT = 12;
   localparam int ST_LOCAL_PASSIVE = 13;
   localparam int ST_LOCAL_THERM = 14;
   localparam int ST_THERM_INPUT = 15;
   // Bits kept by the generic sticky bank.
   localparam logic [15:0] GENERIC_MASK = 16'hE0DF;
   // Hysteresis below a critical limit.
   localparam int HYST_DEG = 5;
   localparam int LSB_PER_DEG = 1;
   localparam int HYST_CNT = HYST_DEG * LSB_PER_DEG;
   typedef logic [STAT_W-1:0] tao_status_type;
endpackage : tao_pkg

// ===== rtl/tao_sticky_if.sv
// Condition, read-clear and flag vectors of the sticky status bank.
// Assumes the owner drives cond and rdClr on the system clock.
`timescale 1ns/1ns
interface tao_sticky_if #(parameter int W = 16);
   logic [W-1:0] cond;
   logic [W-1:0] rdClr;
   logic [W-1:0] flags;
   modport owner (output cond, output rdClr, input flags);
   modport bank (input cond, input rdClr, output flags);
endinterface : tao_sticky_if

// ===== rtl/tao_sticky_bank.sv
// Bank of sticky status flags set by level conditions.
// Assumes rdClr is a one-cycle read strobe per bit.
`timescale 1ns/1ns
module tao_sticky_bank #(
   parameter int W = 16
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Flag vectors.
   tao_sticky_if.bank sif
);
   logic [W-1:0] flags_r;
   logic [W-1:0] flags_nxt;

   if (W < 1) begin : g_chk
      $error("tao_sticky_bank needs W of at least one.");
   end

   // A read clears a flag only once its condition is gone; a live condition wins.
   // clear when gone
   assign flags_nxt = sif.cond | (flags_r & ~sif.rdClr);
   assign sif.flags = flags_r;

   // Flag storage.
   // sticky flag hold
   always_ff @(posedge clk_sys) begin
      if (!nrst) flags_r <= '0;
      else flags_r <= flags_nxt;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   for (genvar i = 0; i < W; i++) begin : g_chk_bit
      property p_cond_sets;
         sif.cond[i] |=> flags_r[i];
      endproperty
      a_cond_sets: assert property (p_cond_sets) else $error("Flag missed its condition.");
      property p_read_clears;
         (flags_r[i] && sif.rdClr[i] && !sif.cond[i]) |=> !flags_r[i];
      endproperty
      a_read_clears: assert property (p_read_clears) else $error("Flag survived a read.");
   end
endmodule : tao_sticky_bank

// ===== rtl/tao_crit_chan.sv
// One over-critical channel: sticky flag with re-arm and pin hold.
// Assumes temperature and limit are signed whole degrees, synchronous.
`timescale 1ns/1ns
module tao_crit_chan #(
   parameter int TW = 8
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic swRst,
   // Temperature and its critical limit.
   input wire logic signed [TW-1:0] temp,
   input wire logic signed [TW-1:0] critLimit,
   // Status read strobe.
   input wire logic rdClr,
   // Results.
   output logic overFlag,
   output logic pinHold
);
   logic flag_r;
   logic armed_r;
   logic hold_r;
   logic hiNow;
   logic loNow;
   logic setNow;
   logic signed [TW:0] relLimit;

   if (TW < 2) begin : g_chk
      $error("tao_crit_chan needs TW of at least two.");
   end

   // Compare one bit wider so the hysteresis point cannot wrap.
   assign relLimit = {critLimit[TW-1], critLimit} - (TW+1)'(tao_pkg::HYST_CNT);
   assign hiNow = temp >= critLimit;
   // A concatenation is unsigned, so the widened temperature is made signed again.
   assign loNow = $signed({temp[TW-1], temp}) <= relLimit;
   assign setNow = hiNow && armed_r;
   assign overFlag = flag_r;
   assign pinHold = hold_r;

   // Flag, re-arm and pin hold; set wins over a read clear.
   // re-arm after falling
   always_ff @(posedge clk_sys) begin
      if (!nrst || swRst) begin
         flag_r <= 1'b0;
         armed_r <= 1'b1;
         hold_r <= 1'b0;
      end else begin
         flag_r <= setNow || (flag_r && !rdClr);
         armed_r <= loNow || (armed_r && !setNow);
         hold_r <= hiNow || (hold_r && !loNow);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst || swRst);

   property p_flag_set;
      setNow |=> flag_r;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("Critical flag not set.");
   property p_no_reassert;
      (!armed_r && !loNow) |=> !$rose(flag_r);
   endproperty
   a_no_reassert: assert property (p_no_reassert) else $error("Flag set before re-arm.");
   property p_read_clear;
      (flag_r && rdClr && !setNow) |=> !flag_r;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("Read did not clear flag.");
   sequence s_hot;
      hiNow ##1 !loNow;
   endsequence
   property p_pin_hold;
      s_hot |-> hold_r;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("Pin released too early.");
endmodule : tao_crit_chan

// ===== bench/tao_host_model.sv
// Host model on the byte register port: write and read tasks.
// Assumes the design answers a read with a registered valid pulse.
`timescale 1ns/1ns
module tao_host_model (
   // Clock.
   input wire logic clk_sys,
   // Register port towards the design.
   output logic regWrEn,
   output logic regRdEn,
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   input wire logic [7:0] regRdData_r,
   input wire logic regRdValid_r
);
   // Idle port after time zero.
   initial begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
   end

   // output config top bit.
   // The data lines are inverted after a write so a stale byte is never trusted.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      regAddr = a;
      regWrData = (a == tao_pkg::ADDR_OUT_CFG) ? (d | 8'h80) : d;
      regWrEn = 1'b1;
      @(negedge clk_sys);
      regWrEn = 1'b0;
      regWrData = ~regWrData;
   endtask : wr

   // One strobe, then a bounded wait for the valid pulse.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(negedge clk_sys);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk_sys);
      regRdEn = 1'b0;
      n = 0;
      while (regRdValid_r !== 1'b1 && n < 4) begin
         @(negedge clk_sys);
         n++;
      end
      d = regRdData_r;
   endtask : rd
endmodule : tao_host_model

// ===== bench/tao_alarm_top_tb_top.sv
// Self-checking bench of the thermal alarm outputs.
// Assumes the host model drives the register port; pins have pull-ups.
`timescale 1ns/1ns
module tao_alarm_top_tb_top;
   localparam logic [7:0] PART_ID_T = 8'h96; // Arbitrary value.
   localparam logic [7:0] MAKER_T = 8'h3C; // Arbitrary value.
   localparam logic [3:0] REV_T = 4'h6; // Arbitrary value.
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic signed [7:0] lTemp = 8'sd0;
   logic signed [7:0] rTemp = 8'sd0;
   logic signed [7:0] lLim = 8'sd100;
   logic signed [7:0] rLim = 8'sd100;
   logic failDet = 1'b0;
   logic [15:0] cond = 16'h0000;
   logic wrEn, rdEn, rdValid, critO, critOe, alertO, alertOe, swPulse;
   logic [7:0] addr, wrData, rdData, v;
   logic signed [7:0] lim;
   int fails = 0;
   int checked = 0;
   // Open-drain wires with pull-ups.
   wire critLevel = critOe ? critO : 1'b1;
   wire alertLevel = alertOe ? alertO : 1'b1;

   always #5 clk_sys = ~clk_sys;

   tao_host_model i_tao_host_model (.clk_sys(clk_sys), .regWrEn(wrEn), .regRdEn(rdEn),
      .regAddr(addr), .regWrData(wrData), .regRdData_r(rdData), .regRdValid_r(rdValid));

   tao_alarm_top #(.PART_ID(PART_ID_T), .MAKER_ID(MAKER_T), .REVISION(REV_T))
      i_tao_alarm_top (.clk_sys(clk_sys), .nrst(nrst),
      .regWrEn(wrEn), .regRdEn(rdEn), .regAddr(addr), .regWrData(wrData),
      .regRdData_r(rdData), .regRdValid_r(rdValid), .localTemp(lTemp),
      .remoteTemp(rTemp), .localCritLimit(lLim), .remoteCritLimit(rLim),
      .remoteFailDet(failDet), .limitCond(cond), .mainCfg_r(), .irqCfg_r(),
      .outCfg_r(), .thermFanEn_r(), .swRstPulse_r(swPulse),
      .critical_alert_pin_i(critLevel), .critical_alert_pin_o(critO),
      .critical_alert_pin_oe_r(critOe), .alert_pin_i(alertLevel),
      .alert_pin_o(alertO), .alert_pin_oe_r(alertOe));

   // Compare tasks, one per kind of result.
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: pin %b, expected %b", $time, got, exp);
      end
   endtask : chk1

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_tao_host_model.rd(a, d);
      chk8(d, exp);
   endtask : rdchk

   task automatic hw(input logic [7:0] a, input logic [7:0] d);
      i_tao_host_model.wr(a, d);
   endtask : hw

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc

   // Read-back of the output config: low nibble fixed, top bit set by the host.
   function automatic logic [7:0] outExp(input logic [7:0] w);
      return {1'b1, w[6:4], 4'h8};
   endfunction : outExp

   // Read-back of the revision register: fan control bit over the revision nibble.
   function automatic logic [7:0] revExp(input logic tf);
      return {tf, 3'b000, REV_T};
   endfunction : revExp

   task automatic give_verdict;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict

   // Watchdog, far above the fewer than two hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      give_verdict();
   end

   initial begin
      void'($urandom(49));
      cyc(4);
      nrst = 1'b1;
      rdchk(tao_pkg::ADDR_MAIN_CFG, tao_pkg::RST_MAIN_CFG);
      rdchk(tao_pkg::ADDR_IRQ_CFG, tao_pkg::RST_IRQ_CFG);
      rdchk(tao_pkg::ADDR_OUT_CFG, tao_pkg::RST_OUT_CFG);
      rdchk(tao_pkg::ADDR_PART_ID, PART_ID_T);
      rdchk(tao_pkg::ADDR_MAKER_ID, MAKER_T);
      rdchk(tao_pkg::ADDR_REV_CFG, revExp(1'b1));
      hw(tao_pkg::ADDR_REV_CFG, 8'h7F);
      rdchk(tao_pkg::ADDR_REV_CFG, revExp(1'b0));
      hw(8'h05, 8'hFF);
      rdchk(8'h05, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom);
         hw(tao_pkg::ADDR_OUT_CFG, v);
         rdchk(tao_pkg::ADDR_OUT_CFG, outExp(v));
      end
      // Generic sticky flags with alerts enabled.
      hw(tao_pkg::ADDR_MAIN_CFG, 8'hD6);
      hw(tao_pkg::ADDR_IRQ_CFG, 8'h3D);
      cond[tao_pkg::ST_LOCAL_HIGH] = 1'b1;
      cyc(3);
      chk1(alertOe, 1'b1);
      chk1(alertLevel, 1'b0);
      cond = 16'h0000;
      cyc(3);
      chk1(alertOe, 1'b1);
      rdchk(tao_pkg::ADDR_STAT1, 8'h40);
      cyc(2);
      chk1(alertOe, 1'b0);
      // Persistent condition survives a read; then the service sequence.
      cond[tao_pkg::ST_LOCAL_LOW] = 1'b1;
      cyc(3);
      rdchk(tao_pkg::ADDR_STAT1, 8'h80);
      rdchk(tao_pkg::ADDR_STAT1, 8'h80);
      chk1(alertOe, 1'b1);
      hw(tao_pkg::ADDR_IRQ_CFG, 8'h2D);
      cyc(3);
      chk1(alertOe, 1'b0);
      rdchk(tao_pkg::ADDR_STAT1, 8'h80);
      cond = 16'h0000;
      cyc(2);
      rdchk(tao_pkg::ADDR_STAT1, 8'h80);
      rdchk(tao_pkg::ADDR_STAT1, 8'h00);
      hw(tao_pkg::ADDR_IRQ_CFG, 8'h3D);
      cyc(3);
      chk1(alertOe, 1'b0);
      // Speed flag alerts; the passive flag sets but its alert stays masked.
      cond[tao_pkg::ST_SPEED_LOW] = 1'b1;
      cond[tao_pkg::ST_LOCAL_PASSIVE] = 1'b1;
      cyc(3);
      chk1(alertOe, 1'b1);
      cond = 16'h0000;
      rdchk(tao_pkg::ADDR_STAT1, 8'h02);
      rdchk(tao_pkg::ADDR_STAT2, 8'h20);
      cyc(2);
      chk1(alertOe, 1'b0);
      // Critical channel at a random limit, pin disabled first.
      hw(tao_pkg::ADDR_OUT_CFG, 8'h00);
      lim = 8'sd40 + 8'($urandom % 40);
      lLim = lim;
      lTemp = lim + 8'($urandom % 5);
      cyc(3);
      chk1(critOe, 1'b0);
      hw(tao_pkg::ADDR_OUT_CFG, 8'h10);
      cyc(3);
      chk1(critOe, 1'b1);
      rdchk(tao_pkg::ADDR_STAT2, 8'h10);
      rdchk(tao_pkg::ADDR_STAT2, 8'h00);
      lTemp = lim - 8'sd4;
      cyc(3);
      chk1(critOe, 1'b1);
      rdchk(tao_pkg::ADDR_STAT2, 8'h00);
      lTemp = lim - 8'sd5;
      cyc(3);
      chk1(critOe, 1'b0);
      lTemp = lim;
      cyc(3);
      rdchk(tao_pkg::ADDR_STAT2, 8'h10);
      lTemp = lim - 8'sd10;
      rLim = lim;
      rTemp = lim;
      cyc(3);
      rdchk(tao_pkg::ADDR_STAT2, 8'h08);
      rTemp = 8'sd0;
      cyc(3);
      chk1(critOe, 1'b0);
      // Corner: small limit, so the release point lies below zero.
      rLim = 8'sd3;
      rTemp = 8'sd3;
      cyc(3);
      rTemp = 8'sd0;
      cyc(3);
      chk1(critOe, 1'b1);
      rTemp = -8'sd2;
      cyc(3);
      chk1(critOe, 1'b0);
      rdchk(tao_pkg::ADDR_STAT2, 8'h08);
      // Sensor failure: a single-cycle detect latches until software reset.
      hw(tao_pkg::ADDR_IRQ_CFG, 8'h35);
      failDet = 1'b1;
      cyc(1);
      failDet = 1'b0;
      cyc(3);
      chk1(critOe, 1'b1);
      chk1(critLevel, 1'b0);
      chk1(alertOe, 1'b0);
      hw(tao_pkg::ADDR_IRQ_CFG, 8'h3D);
      cyc(3);
      chk1(alertOe, 1'b1);
      rdchk(tao_pkg::ADDR_STAT1, 8'h20);
      rdchk(tao_pkg::ADDR_STAT1, 8'h20);
      chk1(critOe, 1'b1);
      hw(tao_pkg::ADDR_IRQ_CFG, 8'hBD);
      chk1(swPulse, 1'b1);
      cyc(3);
      chk1(swPulse, 1'b0);
      rdchk(tao_pkg::ADDR_OUT_CFG, tao_pkg::RST_OUT_CFG);
      rdchk(tao_pkg::ADDR_REV_CFG, revExp(1'b1));
      hw(tao_pkg::ADDR_OUT_CFG, 8'h10);
      cyc(3);
      chk1(critOe, 1'b0);
      rdchk(tao_pkg::ADDR_STAT1, 8'h00);
      give_verdict();
   end
endmodule : tao_alarm_top_tb_top
